/* File: bench/static_mem_model.sv */
// behavioural asynchronous static memory for the read sequencer bench
// assumes a byte-addressed array whose contents follow from the address
`timescale 1ns/1ns
module static_mem_model
    import static_mem_pkg::*;
(
    // clock
    input  wire logic                 i_clk,
    // memory pins
    input  wire logic [NUM_BANKS-1:0] i_bank_select_low,
    input  wire logic [XADDR_W-1:0]   i_address,
    input  wire logic                 i_output_enable_low,
    // access time in cycles after the address settles
    input  wire logic [CNT_W-1:0]     i_latency,
    // read data, narrow parts on the low lanes
    output logic [DATA_W-1:0]         o_rdata
);
    logic [CNT_W-1:0]   age_q = 15'h0000;
    logic [XADDR_W-1:0] addr_q = 28'h000_0000;
    logic [DATA_W-1:0]  junk_q = 32'h3c3c_a5a5;
    logic               driving;
    logic               settled;
    logic [XADDR_W-1:0] a1, a2, a3;

    // data shows only once the part is selected, enabled and past its access time
    assign driving = (i_bank_select_low != 4'hf) && !i_output_enable_low;
    assign settled = driving && (i_address == addr_q) && (age_q >= i_latency);
    assign a1 = i_address + 28'h000_0001;
    assign a2 = i_address + 28'h000_0002;
    assign a3 = i_address + 28'h000_0003;
    // a released bus toggles every cycle, so a stale capture never looks right
    assign o_rdata = settled ? ({a3[7:0], a2[7:0], a1[7:0], i_address[7:0]} ^ 32'ha5a5_a5a5)
                             : junk_q;

    // access age restarts whenever the address moves
    always_ff @(posedge i_clk)
    begin
        junk_q <= ~junk_q;
        addr_q <= i_address;
        age_q  <= (driving && i_address == addr_q) ? age_q + 15'h0001 : 15'h0000;
    end
endmodule : static_mem_model

/* File: bench/test_static_memory_read_timing.sv */
// self-checking bench for the static memory read sequencer
// assumes the memory model above as the far side, one request at a time
`timescale 1ns/1ns
module test_static_memory_read_timing;
    import static_mem_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, i_req = 1'b0, i_write = 1'b0;
    logic [DATA_W-1:0] i_addr = 32'h0000_0000, i_wdata = 32'h0000_0000, o_rdata, mem_rdata;
    logic [1:0] i_size = SIZE_WORD;
    logic [NUM_BANKS-1:0][1:0] i_bank_width;
    logic [NUM_BANKS-1:0] i_page_mode, i_extended_wait_enable, o_static_bank_select_low;
    logic [NUM_BANKS-1:0][WAIT_W-1:0] i_read_wait_count, i_write_wait_count, i_page_read_wait_count;
    logic [NUM_BANKS-1:0][OEN_W-1:0] i_output_enable_delay;
    logic [NUM_BANKS-1:0][TURN_W-1:0] i_turnaround_wait_count;
    logic [EXT_W-1:0] i_long_wait_timer = 10'h000;
    logic [XADDR_W-1:0] o_external_address_out;
    logic [CNT_W-1:0] lat = 15'h0000;
    logic o_ready, o_rdata_valid, o_output_enable_low, o_write_enable_low, o_mem_wdata_oe;
    logic [DATA_W-1:0] o_mem_wdata;
    int err_count = 0;
    int total_checks = 0;

    static_memory_read_timing i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
        .i_addr(i_addr), .i_write(i_write), .i_size(i_size), .i_wdata(i_wdata),
        .o_ready(o_ready), .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata),
        .i_bank_width(i_bank_width), .i_page_mode(i_page_mode),
        .i_extended_wait_enable(i_extended_wait_enable), .i_read_wait_count(i_read_wait_count),
        .i_write_wait_count(i_write_wait_count), .i_page_read_wait_count(i_page_read_wait_count),
        .i_output_enable_delay(i_output_enable_delay),
        .i_turnaround_wait_count(i_turnaround_wait_count), .i_long_wait_timer(i_long_wait_timer),
        .o_static_bank_select_low(o_static_bank_select_low),
        .o_external_address_out(o_external_address_out),
        .o_output_enable_low(o_output_enable_low), .o_write_enable_low(o_write_enable_low),
        .o_mem_wdata(o_mem_wdata), .o_mem_wdata_oe(o_mem_wdata_oe), .i_mem_rdata(mem_rdata));

    static_mem_model i_mem (.i_clk(i_clk), .i_bank_select_low(o_static_bank_select_low),
        .i_address(o_external_address_out), .i_output_enable_low(o_output_enable_low),
        .i_latency(lat), .o_rdata(mem_rdata));

    // 25 MHz system clock
    always #20 i_clk = ~i_clk;

    // expected word of the byte-addressed model at an aligned address
    function automatic logic [DATA_W-1:0] word_at(input logic [XADDR_W-1:0] a);
        return {a[7:0] + 8'h03, a[7:0] + 8'h02, a[7:0] + 8'h01, a[7:0]} ^ 32'ha5a5_a5a5;
    endfunction : word_at

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic set_bank(input int b, w, pg_en, ew, rd, wr, pg, oen, turn);
        i_bank_width[b] = 2'(w);
        i_page_mode[b] = 1'(pg_en);
        i_extended_wait_enable[b] = 1'(ew);
        i_read_wait_count[b] = 5'(rd);
        i_write_wait_count[b] = 5'(wr);
        i_page_read_wait_count[b] = 5'(pg);
        i_output_enable_delay[b] = 4'(oen);
        i_turnaround_wait_count[b] = 4'(turn);
    endtask : set_bank

    // one word transfer, entered and left at a falling edge so calls run back to back
    task automatic xfer(input int bank, input logic [27:0] xa, input logic wr, input int exp_low,
                        input int exp_oen);
        int low, sel_at, oe_at;
        logic [3:0] sel_exp;
        low = 0;
        sel_at = -1;
        oe_at = -1;
        sel_exp = ~(4'h1 << bank);
        i_req = 1'b1;
        i_addr = {2'b00, 2'(bank), xa};
        i_write = wr;
        i_wdata = ~word_at(xa);
        @(posedge i_clk);
        @(negedge i_clk);
        i_req = 1'b0;
        while (o_ready !== 1'b1 && low < 2000)
        begin
            if (o_static_bank_select_low !== 4'hf && sel_at < 0)
            begin
                sel_at = low;
                check("select", o_static_bank_select_low, sel_exp);
                check("ext address", o_external_address_out, xa);
                check("write strobe", o_write_enable_low, !wr);
                check("write drive", o_mem_wdata_oe, wr);
                if (wr)
                    check("write data", o_mem_wdata, ~word_at(xa));
            end
            if (o_output_enable_low === 1'b0 && oe_at < 0)
                oe_at = low;
            if (o_output_enable_low === 1'b0 && o_static_bank_select_low[bank] !== 1'b0)
                check("oe without select", 1, 0);
            low++;
            @(negedge i_clk);
        end
        check("ready low cycles", low, exp_low);
        check("oe at end", o_output_enable_low, 1);
        check("select at end", o_static_bank_select_low, 4'hf);
        check("rdata valid", o_rdata_valid, !wr);
        if (!wr)
        begin
            check("read word", o_rdata, word_at(xa));
            check("oe delay", oe_at - sel_at, exp_oen);
        end
    endtask : xfer

    // word bank: minimum, read waits, oe delay, boundaries, then back to back
    task automatic t_single;
        int rd[5] = '{0, 2, 0, 31, 1};
        int oe[5] = '{0, 0, 2, 0, 15};
        for (int k = 0; k < 5; k++)
        begin
            @(negedge i_clk);
            set_bank(0, WID_32, 0, 0, rd[k], 0, 0, oe[k], 0);
            lat = 15'(rd[k]);
            xfer(0, 28'h000_0100 + 28'(k * 4), 1'b0, 6 + rd[k] + oe[k], oe[k]);
        end
        xfer(0, 28'h000_0200, 1'b0, 22, 15);
        $display("single read test done");
    endtask : t_single

    // narrow banks split a word read into beats, bus stalled throughout
    task automatic t_width;
        @(negedge i_clk);
        set_bank(3, WID_8, 0, 0, 1, 0, 0, 1, 0);
        set_bank(2, WID_16, 0, 0, 0, 0, 0, 0, 0);
        lat = 15'h0001;
        xfer(3, 28'h000_0040, 1'b0, 17, 1);
        lat = 15'h0000;
        xfer(2, 28'h000_0080, 1'b0, 8, 0);
        $display("width test done");
    endtask : t_width

    // page mode: first beat on read wait, later beats on page wait
    task automatic t_page;
        @(negedge i_clk);
        set_bank(3, WID_8, 1, 0, 3, 0, 1, 0, 0);
        lat = 15'h0001;
        xfer(3, 28'h000_00c0, 1'b0, 18, 0);
        $display("page test done");
    endtask : t_page

    // long wait on one bank only, for reads and writes
    task automatic t_ext;
        @(negedge i_clk);
        i_long_wait_timer = 10'h002;
        set_bank(1, WID_32, 0, 1, 0, 0, 0, 0, 0);
        set_bank(0, WID_32, 0, 0, 0, 0, 0, 0, 0);
        lat = 15'h0020;
        xfer(1, 28'h000_0300, 1'b0, 38, 0);
        lat = 15'h0000;
        xfer(0, 28'h000_0304, 1'b0, 6, 0);
        xfer(1, 28'h000_0308, 1'b1, 38, 0);
        $display("extended wait test done");
    endtask : t_ext

    // write waits, turnaround only after a read
    task automatic t_write;
        @(negedge i_clk);
        set_bank(0, WID_32, 0, 0, 0, 4, 0, 0, 3);
        xfer(0, 28'h000_0400, 1'b0, 6, 0);
        xfer(0, 28'h000_0404, 1'b1, 13, 0);
        xfer(0, 28'h000_0408, 1'b1, 10, 0);
        $display("write test done");
    endtask : t_write

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    // the whole run needs a few hundred cycles; 5000 means a hang
    initial
    begin
        #(40 * 5000);
        err_count++;
        conclude();
    end

    // banks are set up before any request reaches them
    initial
    begin
        for (int b = 0; b < NUM_BANKS; b++)
            set_bank(b, WID_32, 0, 0, 0, 0, 0, 0, 0);
        repeat (10) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        check("ready idle", o_ready, 1);
        check("select idle", o_static_bank_select_low, 4'hf);
        t_single();
        t_width();
        t_page();
        t_ext();
        t_write();
        conclude();
    end
endmodule : test_static_memory_read_timing

/* File: rtl/bank_timing_if.sv */
// timing of the addressed bank, handed from the selector to the sequencer
// assumes the sequencer drives the bank index from a register
`timescale 1ns/1ns
interface bank_timing_if;
    import static_mem_pkg::*;
    logic [BANK_W-1:0] bank;
    logic [1:0]        width;
    logic              page_en;
    logic [OEN_W-1:0]  oen;
    logic [CNT_W-1:0]  rd_cyc;
    logic [CNT_W-1:0]  wr_cyc;
    logic [CNT_W-1:0]  page_cyc;
    logic [TURN_W-1:0] turn;
    modport sel (input bank, output width, page_en, oen, rd_cyc, wr_cyc, page_cyc, turn);
    modport seq (output bank, input width, page_en, oen, rd_cyc, wr_cyc, page_cyc, turn);
endinterface : bank_timing_if

/* File: rtl/bank_timing_select.sv */
// per-bank wait selection, extended wait substituted per bank
// assumes configuration ports stay stable while a transfer runs
`timescale 1ns/1ns
module bank_timing_select
    import static_mem_pkg::*;
(
    // per-bank configuration and the shared long wait timer
    input  wire logic [NUM_BANKS-1:0][1:0]        i_bank_width,
    input  wire logic [NUM_BANKS-1:0]             i_page_mode,
    input  wire logic [NUM_BANKS-1:0]             i_extended_wait_enable,
    input  wire logic [NUM_BANKS-1:0][WAIT_W-1:0] i_read_wait_count,
    input  wire logic [NUM_BANKS-1:0][WAIT_W-1:0] i_write_wait_count,
    input  wire logic [NUM_BANKS-1:0][WAIT_W-1:0] i_page_read_wait_count,
    input  wire logic [NUM_BANKS-1:0][OEN_W-1:0]  i_output_enable_delay,
    input  wire logic [NUM_BANKS-1:0][TURN_W-1:0] i_turnaround_wait_count,
    input  wire logic [EXT_W-1:0]                 i_long_wait_timer,
    // towards the sequencer
    bank_timing_if.sel                            tim
);
    logic [NUM_BANKS-1:0][CNT_W-1:0] rd_cyc;
    logic [NUM_BANKS-1:0][CNT_W-1:0] wr_cyc;
    logic [NUM_BANKS-1:0][CNT_W-1:0] pg_cyc;
    logic [CNT_W-1:0]                ext_cyc;

    // long wait is shared, each bank chooses it on its own enable
    assign ext_cyc = CNT_W'(i_long_wait_timer) << EXT_SHIFT;

    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++)
        begin : g_bank
            // extended wait times both directions of that bank only
            assign rd_cyc[b] = i_extended_wait_enable[b] ? ext_cyc
                             : CNT_W'(i_read_wait_count[b]);
            assign wr_cyc[b] = i_extended_wait_enable[b] ? ext_cyc
                             : CNT_W'(i_write_wait_count[b]);
            assign pg_cyc[b] = CNT_W'(i_page_read_wait_count[b]);
        end
    endgenerate

    // select the addressed bank
    assign tim.width    = i_bank_width[tim.bank];
    assign tim.page_en  = i_page_mode[tim.bank];
    assign tim.oen      = i_output_enable_delay[tim.bank];
    assign tim.rd_cyc   = rd_cyc[tim.bank];
    assign tim.wr_cyc   = wr_cyc[tim.bank];
    assign tim.page_cyc = pg_cyc[tim.bank];
    assign tim.turn     = i_turnaround_wait_count[tim.bank];
endmodule : bank_timing_select

/* File: rtl/static_mem_pkg.sv */
// constants for the static memory read sequencer
// assumes four banks on one 25 MHz system clock
package static_mem_pkg;
    localparam int NUM_BANKS   = 4;
    localparam int BANK_W      = 2;
    localparam int XADDR_W     = 28;
    localparam int DATA_W      = 32;
    localparam int WAIT_W      = 5;   // read, write and page wait fields
    localparam int OEN_W       = 4;   // output enable delay, 0..15
    localparam int TURN_W      = 4;
    localparam int EXT_W       = 10;  // shared long wait field
    localparam int CNT_W       = 15;  // holds 16368 plus oe delay
    localparam int EXT_SHIFT   = 4;   // long wait counts in steps of 16
    // bank address field inside the system address
    localparam int BANK_LSB    = 28;
    // setup cycles before the chip select: transaction, arbitration, 2 internal
    localparam logic [2:0] PROC_LAST = 3'h3;
    localparam logic [3:0] OEN_SAT   = 4'hf;
    // bank data width codes and transfer size codes
    localparam logic [1:0] WID_8     = 2'h0;
    localparam logic [1:0] WID_16    = 2'h1;
    localparam logic [1:0] WID_32    = 2'h2;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'b000_0001,
        ST_PROC    = 7'b000_0010,
        ST_TURN    = 7'b000_0100,
        ST_ASSERT  = 7'b000_1000,
        ST_WAIT    = 7'b001_0000,
        ST_CAPTURE = 7'b010_0000,
        ST_DONE    = 7'b100_0000
    } seq_state_t;
endpackage : static_mem_pkg

/* File: rtl/static_memory_read_timing.sv */
// static memory sequencer: system bus transfer to external ROM/SRAM/flash beats
// assumes a single outstanding request and configuration held stable meanwhile
`timescale 1ns/1ns
module static_memory_read_timing
    import static_mem_pkg::*;
(
    // clock and reset
    input  wire logic                             i_clk,
    input  wire logic                             i_rst,
    // system bus request
    input  wire logic                             i_req,
    input  wire logic [DATA_W-1:0]                i_addr,
    input  wire logic                             i_write,
    input  wire logic [1:0]                       i_size,
    input  wire logic [DATA_W-1:0]                i_wdata,
    // system bus answer
    output logic                                  o_ready,
    output logic                                  o_rdata_valid,
    output logic [DATA_W-1:0]                     o_rdata,
    // bank configuration
    input  wire logic [NUM_BANKS-1:0][1:0]        i_bank_width,
    input  wire logic [NUM_BANKS-1:0]             i_page_mode,
    input  wire logic [NUM_BANKS-1:0]             i_extended_wait_enable,
    input  wire logic [NUM_BANKS-1:0][WAIT_W-1:0] i_read_wait_count,
    input  wire logic [NUM_BANKS-1:0][WAIT_W-1:0] i_write_wait_count,
    input  wire logic [NUM_BANKS-1:0][WAIT_W-1:0] i_page_read_wait_count,
    input  wire logic [NUM_BANKS-1:0][OEN_W-1:0]  i_output_enable_delay,
    input  wire logic [NUM_BANKS-1:0][TURN_W-1:0] i_turnaround_wait_count,
    input  wire logic [EXT_W-1:0]                 i_long_wait_timer,
    // external static memory
    output logic [NUM_BANKS-1:0]                  o_static_bank_select_low,
    output logic [XADDR_W-1:0]                    o_external_address_out,
    output logic                                  o_output_enable_low,
    output logic                                  o_write_enable_low,
    output logic [DATA_W-1:0]                     o_mem_wdata,
    output logic                                  o_mem_wdata_oe,
    input  wire logic [DATA_W-1:0]                i_mem_rdata
);
    bank_timing_if tim ();

    seq_state_t          state_q, state_d;
    logic [CNT_W-1:0]    cnt_q;
    logic [1:0]          beat_q;
    logic [1:0]          last_beat_q;
    logic [OEN_W-1:0]    ela_q;
    logic                write_q;
    logic                last_read_q;
    logic [BANK_W-1:0]   bank_q;
    logic [XADDR_W-1:0]  xaddr_q;
    logic [DATA_W-1:0]   rdata_q;
    logic [DATA_W-1:0]   wdata_q;

    bank_timing_select u_sel (
        .i_bank_width           (i_bank_width),
        .i_page_mode            (i_page_mode),
        .i_extended_wait_enable (i_extended_wait_enable),
        .i_read_wait_count      (i_read_wait_count),
        .i_write_wait_count     (i_write_wait_count),
        .i_page_read_wait_count (i_page_read_wait_count),
        .i_output_enable_delay  (i_output_enable_delay),
        .i_turnaround_wait_count(i_turnaround_wait_count),
        .i_long_wait_timer      (i_long_wait_timer),
        .tim                    (tim)
    );
    assign tim.bank = bank_q;

    // decode of the sequencer state
    wire accept    = i_req && (state_q == ST_IDLE || state_q == ST_DONE);
    wire cs_active = state_q == ST_ASSERT || state_q == ST_WAIT
                  || state_q == ST_CAPTURE;
    wire cnt_zero  = cnt_q == '0;
    wire beat_end  = beat_q == last_beat_q;
    wire do_turn   = write_q && last_read_q && tim.turn != '0;
    wire [1:0] req_bank_w = i_bank_width[i_addr[BANK_LSB +: BANK_W]];
    // beats per transfer: size over bank width, never below one
    wire [1:0] req_last = (i_size > req_bank_w)
                        ? 2'((3'h1 << (i_size - req_bank_w)) - 3'h1) : 2'h0;
    // oe delay only on the first beat; later beats take page wait in page mode, else read wait
    wire [CNT_W-1:0] rd_first = tim.rd_cyc + CNT_W'(tim.oen);
    wire [CNT_W-1:0] beat_cyc = write_q ? tim.wr_cyc
                              : (beat_q != 2'h0 && tim.page_en) ? tim.page_cyc
                              : (beat_q != 2'h0) ? tim.rd_cyc : rd_first;
    wire [4:0] lane_sh = 5'(beat_q) << (3 + tim.width);
    wire [XADDR_W-1:0] step = XADDR_W'(1) << tim.width;

    // next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:    if (accept) state_d = ST_PROC;
            ST_PROC:    if (cnt_zero) state_d = do_turn ? ST_TURN : ST_ASSERT;
            ST_TURN:    if (cnt_zero) state_d = ST_ASSERT;
            ST_ASSERT:  state_d = (beat_cyc == '0) ? ST_CAPTURE : ST_WAIT;
            ST_WAIT:    if (cnt_zero) state_d = ST_CAPTURE;
            ST_CAPTURE: state_d = beat_end ? ST_DONE : ST_ASSERT;
            ST_DONE:    state_d = accept ? ST_PROC : ST_IDLE;
            default:    state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // cycle counter shared by setup, turnaround and wait phases
    // a zero turn count wraps here; harmless, since the assert state reloads it
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            cnt_q <= '0;
        else if (accept)
            cnt_q <= CNT_W'(PROC_LAST);
        else if (state_q == ST_PROC && cnt_zero)
            cnt_q <= CNT_W'(tim.turn) - CNT_W'(1);
        else if (state_q == ST_ASSERT)
            cnt_q <= beat_cyc - CNT_W'(1);
        else if (!cnt_zero)
            cnt_q <= cnt_q - CNT_W'(1);
    end

    // request capture; bank index steers the timing selector
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            write_q     <= 1'b0;
            bank_q      <= '0;
            last_beat_q <= 2'h0;
        end
        else if (accept)
        begin
            write_q     <= i_write;
            bank_q      <= i_addr[BANK_LSB +: BANK_W];
            last_beat_q <= req_last;
        end
    end

    // beat index and external address, stepped by bank width per beat
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            beat_q  <= 2'h0;
            xaddr_q <= '0;
        end
        else if (accept)
        begin
            beat_q  <= 2'h0;
            xaddr_q <= i_addr[XADDR_W-1:0];
        end
        else if (state_q == ST_CAPTURE && !beat_end)
        begin
            beat_q  <= beat_q + 2'h1;
            xaddr_q <= xaddr_q + step;
        end
    end

    // cycles since chip select went low, saturating; gates output enable
    always_ff @(posedge i_clk)
    begin
        if (i_rst || !cs_active)
            ela_q <= '0;
        else if (ela_q != OEN_SAT)
            ela_q <= ela_q + 4'h1;
    end

    // read data assembled lane by lane, first beat in the low bytes
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rdata_q <= '0;
        else if (state_q == ST_CAPTURE && !write_q)
        begin
            case (tim.width)
                WID_8:   rdata_q[lane_sh +: 8]  <= i_mem_rdata[7:0];
                WID_16:  rdata_q[lane_sh +: 16] <= i_mem_rdata[15:0];
                default: rdata_q                <= i_mem_rdata;
            endcase
        end
    end

    // write data shifts down one bank width after each beat
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            wdata_q <= '0;
        else if (accept)
            wdata_q <= i_wdata;
        else if (state_q == ST_CAPTURE)
            wdata_q <= wdata_q >> (6'h8 << tim.width);
    end

    // remembers direction of the last external transfer for turnaround
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            last_read_q <= 1'b0;
        else if (state_q == ST_DONE)
            last_read_q <= !write_q;
    end

    // bus answer: ready held low from acceptance until the word is ready
    assign o_ready       = state_q == ST_IDLE || state_q == ST_DONE;
    assign o_rdata_valid = state_q == ST_DONE && !write_q;
    assign o_rdata       = rdata_q;

    // external pins; oe and cs fall away together since both use cs_active
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++)
        begin : g_cs
            assign o_static_bank_select_low[b] = !(cs_active && bank_q == b);
        end
    endgenerate
    assign o_external_address_out = xaddr_q;
    assign o_output_enable_low    = !(cs_active && !write_q
                                      && ela_q >= tim.oen);
    // write strobe timing is not refined here: held over the whole beat
    assign o_write_enable_low     = !(cs_active && write_q);
    assign o_mem_wdata            = wdata_q;
    assign o_mem_wdata_oe         = cs_active && write_q;

    // checks
    wire cs_any = !(&o_static_bank_select_low);
    wire [1:0] a_bank = i_addr[BANK_LSB +: BANK_W];
    wire plain_rd = accept && !i_write && i_size == SIZE_WORD
                 && req_bank_w == WID_32 && !i_extended_wait_enable[a_bank]
                 && i_output_enable_delay[a_bank] == 4'h0;
    logic [2:0] cap_cnt_q;
    always_ff @(posedge i_clk)
    begin
        if (i_rst || accept)
            cap_cnt_q <= 3'h0;
        else if (state_q == ST_CAPTURE)
            cap_cnt_q <= cap_cnt_q + 3'h1;
    end

    sequence s_setup;
        !cs_any [*4];
    endsequence
    sequence s_stall6;
        !o_ready [*6];
    endsequence

    AST_MIN_STALL: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && !i_write |=> s_stall6)
        else $error("read answered before six wait states");
    AST_ZERO_WAIT: assert property (@(posedge i_clk) disable iff (i_rst)
        plain_rd && i_read_wait_count[a_bank] == 5'h00 |=> s_stall6 ##1 o_rdata_valid)
        else $error("zero wait read not done after six wait states");
    AST_TWO_WAIT: assert property (@(posedge i_clk) disable iff (i_rst)
        plain_rd && i_read_wait_count[a_bank] == 5'h02 |=> s_stall6 ##1 !o_ready [*2]
        ##1 o_rdata_valid)
        else $error("two wait read not done after eight wait states");
    AST_SETUP: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && !i_write |=> s_setup ##1 cs_any)
        else $error("chip select not driven after four setup cycles");
    AST_OE_CS: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_output_enable_low) |-> $fell(cs_any))
        else $error("output enable released apart from chip select");
    AST_OE_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(cs_any) && !write_q && tim.oen == 4'h0 |-> !o_output_enable_low)
        else $error("output enable late with zero delay");
    AST_OE_LATE: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(cs_any) && !write_q && tim.oen != 4'h0 |-> o_output_enable_low)
        else $error("output enable early despite delay");
    AST_BYTE_BEATS: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rdata_valid && tim.width == WID_8 && last_beat_q == 2'h3 |-> cap_cnt_q == 3'h4)
        else $error("byte bank word read without four captures");
    AST_ADDR: assert property (@(posedge i_clk) disable iff (i_rst)
        accept && !i_write |=> ##4 cs_any
        && o_external_address_out == $past(i_addr[XADDR_W-1:0], 5))
        else $error("external address wrong at chip select");
    // once enabled, output enable stays low until the select is released
    AST_OE_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
        cs_any && !o_output_enable_low |=> !cs_any || !o_output_enable_low)
        else $error("output enable dropped while select still low");
    AST_READY_LOW: assert property (@(posedge i_clk) disable iff (i_rst)
        cs_any |-> !o_ready)
        else $error("ready high during external access");
endmodule : static_memory_read_timing
